/* File: src/adcs_pkg.sv */
/*
 * adcs_pkg: shared constants, register layout and helpers for the
 * converter sequencer.
 * Assumes a 100 MHz system clock and 32-bit AXI4-Lite register access.
 */
package adcs_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_RES_HI  = 8'h08;
  localparam logic [7:0] ADDR_RES_LO  = 8'h0C;
  localparam logic [7:0] ADDR_IRQF    = 8'h10;
  localparam logic [7:0] ADDR_IRQE    = 8'h14;
  localparam logic [7:0] ADDR_IRQP    = 8'h18;
  localparam logic [7:0] ADDR_PORT    = 8'h1C;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] CTRL0_RST    = 8'h00;
  localparam logic [7:0] CTRL1_RST    = 8'h00;
  localparam logic [7:0] IRQF_RST     = 8'h00;
  localparam logic [7:0] IRQE_RST     = 8'h00;
  localparam logic [7:0] IRQP_RST     = 8'hFF;
  localparam int         DONE_BIT     = 6;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  // ************************************************************
  // timing: conversion length and abort wait in bit periods
  // ************************************************************
  localparam logic [3:0] CONV_TADS    = 4'd12;
  localparam logic [3:0] ABORT_TADS   = 4'd2;
  localparam logic [3:0] TRIG_MODE    = 4'b1011;
  localparam logic [2:0] CODE_RC      = 3'b011;

  // control register 0 and 1 field layouts
  typedef struct packed {
    logic [1:0] clk_sel_lo;
    logic [2:0] input_channel_select;
    logic       go;
    logic       unused;
    logic       converter_power_on;
  } adcs_ctrl0_t;

  typedef struct packed {
    logic       result_format_select;
    logic       clk_sel_hi;
    logic [1:0] unused;
    logic [3:0] analog_pin_config;
  } adcs_ctrl1_t;

  typedef enum logic [1:0] {
    ST_ACQ   = 2'b00,
    ST_CONV  = 2'b01,
    ST_ABORT = 2'b10
  } adcs_state_t;

  // oscillator periods per bit period for a divider code
  function automatic logic [6:0] adcs_tad_div(input logic [2:0] code);
    case (code)
      3'b000:  adcs_tad_div = 7'd2;
      3'b100:  adcs_tad_div = 7'd4;
      3'b001:  adcs_tad_div = 7'd8;
      3'b101:  adcs_tad_div = 7'd16;
      3'b010:  adcs_tad_div = 7'd32;
      3'b110:  adcs_tad_div = 7'd64;
      default: adcs_tad_div = 7'd2;
    endcase
  endfunction

  // pins that are analog for a pin configuration, bit n = channel n
  function automatic logic [7:0] adcs_analog_mask(input logic [3:0] cfg);
    case (cfg)
      4'b0000, 4'b0001, 4'b1000: adcs_analog_mask = 8'hFF;
      4'b0010, 4'b0011, 4'b1100: adcs_analog_mask = 8'h1F;
      4'b0100, 4'b0101:          adcs_analog_mask = 8'h0B;
      4'b1001, 4'b1010, 4'b1011: adcs_analog_mask = 8'h3F;
      4'b1101:                   adcs_analog_mask = 8'h0F;
      4'b1110:                   adcs_analog_mask = 8'h01;
      4'b1111:                   adcs_analog_mask = 8'h0D;
      default:                   adcs_analog_mask = 8'h00;
    endcase
  endfunction

endpackage

/* File: src/adcs_tad_gen.sv */
/*
 * adcs_tad_gen: bit-period tick generator.
 * Assumes the caller pulses restart at conversion start; the RC tick
 * input is asynchronous and slow against the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module adcs_tad_gen
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // control
  input  wire logic       restart,
  input  wire logic [2:0] code,
  input  wire logic       rc_tick_in,
  // tick out
  output logic            tad_tick
);

  logic [6:0] cnt_r, cnt_nxt;
  logic       tick_nxt;
  logic       rc_s1_r, rc_s2_r, rc_s3_r;
  logic       use_rc;

  // ************************************************************
  // rc tick synchroniser, edge taken past the second stage
  // ************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= rc_tick_in;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end

  assign use_rc = (code[1:0] == CODE_RC[1:0]);

  // divider; restart aligns the first period to the start edge
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (restart) begin
      cnt_nxt = 7'd0;
    end else if (use_rc) begin
      cnt_nxt  = 7'd0;
      tick_nxt = rc_s2_r & ~rc_s3_r;
    end else if (cnt_r >= adcs_tad_div(code) - 7'd1) begin
      cnt_nxt  = 7'd0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 7'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= 7'd0;
    end else begin
      cnt_r  <= cnt_nxt;
    end
  end

  // tick straight from the divider: the sequencer acts on the edge that
  // closes each period, so a conversion on a divider code spans exactly twelve periods
  assign tad_tick = tick_nxt;

endmodule // adcs_tad_gen

`default_nettype wire

/* File: src/adcs_sequencer.sv */
/*
 * adcs_sequencer: 10-bit successive-approximation conversion sequencer
 * with AXI4-Lite register access.
 * Assumes the analog array presents its result on sar_result_in by the
 * last bit period, and that compare-unit trigger pulses last one cycle.
 */
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module adcs_sequencer
  import adcs_pkg::*;
(
  // clock and resets
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        soft_rst,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog array side
  input  wire logic [9:0]  sar_result_in,
  input  wire logic        rc_tick_in,
  output logic             sample_en,
  output logic             sar_step,
  output logic [2:0]       input_channel_select,
  // compare unit and port
  input  wire logic        special_trigger,
  input  wire logic [3:0]  compare_unit_mode,
  output logic             timer_reset,
  input  wire logic [7:0]  port_pins_in
);

  // ************************************************************
  // state
  // ************************************************************
  adcs_state_t st_r, st_nxt;
  adcs_ctrl0_t ctrl0_r, ctrl0_nxt;
  adcs_ctrl1_t ctrl1_r, ctrl1_nxt;
  logic [7:0]  res_hi_r, res_hi_nxt, res_lo_r, res_lo_nxt;
  logic [7:0]  irqf_r, irqf_nxt, irqe_r, irqe_nxt, irqp_r, irqp_nxt;
  logic [3:0]  tad_cnt_r, tad_cnt_nxt;
  logic        samp_r, samp_nxt, step_r, step_nxt, trst_r, trst_nxt;
  logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        arready_r, arready_nxt;
  logic        wr_fire, start, abort, done, tad_tick;
  logic [2:0]  clk_code;
  logic [7:0]  wd;

  assign clk_code = {ctrl1_r.clk_sel_hi, ctrl0_r.clk_sel_lo};
  assign wr_fire  = aw_have_r & w_have_r & ~bvalid_r;
  assign wd       = wdata_r;

  adcs_tad_gen u_tad (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .restart    (start),
    .code       (clk_code),
    .rc_tick_in (rc_tick_in),
    .tad_tick   (tad_tick)
  );

  // ************************************************************
  // axi4-lite handshakes
  // ************************************************************
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && !aw_have_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata[7:0];
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = (awaddr_r[7:5] == 3'd0 && awaddr_r[1:0] == 2'd0)
                   ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt  = 1'b0;
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
    end
  end

  // read mux; unimplemented bits read zero, analog pins read low
  always_comb begin
    rvalid_nxt  = rvalid_r;
    arready_nxt = arready_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt  = 1'b1;
      arready_nxt = 1'b0;
      rresp_nxt   = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL0:  rdata_nxt = {24'h00_0000, ctrl0_r & 8'hFD};
        ADDR_CTRL1:  rdata_nxt = {24'h00_0000, ctrl1_r & 8'hCF};
        ADDR_RES_HI: rdata_nxt = {24'h00_0000, res_hi_r};
        ADDR_RES_LO: rdata_nxt = {24'h00_0000, res_lo_r};
        ADDR_IRQF:   rdata_nxt = {24'h00_0000, irqf_r};
        ADDR_IRQE:   rdata_nxt = {24'h00_0000, irqe_r};
        ADDR_IRQP:   rdata_nxt = {24'h00_0000, irqp_r};
        ADDR_PORT:   rdata_nxt = {24'h00_0000, port_pins_in &
                       ~adcs_analog_mask(ctrl1_r.analog_pin_config)};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // ************************************************************
  // registers and conversion sequencing
  // ************************************************************
  always_comb begin
    st_nxt      = st_r;
    ctrl0_nxt   = ctrl0_r;
    ctrl1_nxt   = ctrl1_r;
    res_hi_nxt  = res_hi_r;
    res_lo_nxt  = res_lo_r;
    irqf_nxt    = irqf_r;
    irqe_nxt    = irqe_r;
    irqp_nxt    = irqp_r;
    tad_cnt_nxt = tad_cnt_r;
    start       = 1'b0;
    abort       = 1'b0;
    done        = 1'b0;
    trst_nxt    = special_trigger && (compare_unit_mode == TRIG_MODE);
    // software writes; the start flag only acts if power was already on
    if (wr_fire && wstrb0_r) begin
      case (awaddr_r)
        ADDR_CTRL0: begin
          ctrl0_nxt        = adcs_ctrl0_t'(wd);
          ctrl0_nxt.unused = 1'b0;
          if (st_r == ST_CONV && (!wd[2] || !wd[0])) begin
            abort = 1'b1;
          end else if (st_r == ST_CONV) begin
            ctrl0_nxt.go = 1'b1;
          end else if (wd[2] && ctrl0_r.converter_power_on &&
                       st_r == ST_ACQ) begin
            start = 1'b1;
          end else begin
            ctrl0_nxt.go = 1'b0;
          end
        end
        ADDR_CTRL1: ctrl1_nxt = adcs_ctrl1_t'(wd & 8'hCF);
        ADDR_RES_HI: if (!ctrl0_r.converter_power_on) res_hi_nxt = wd;
        ADDR_RES_LO: if (!ctrl0_r.converter_power_on) res_lo_nxt = wd;
        ADDR_IRQF:   irqf_nxt = wd;
        ADDR_IRQE:   irqe_nxt = wd;
        ADDR_IRQP:   irqp_nxt = wd;
        default:     ;
      endcase
    end
    // special event trigger, only while powered and acquiring
    if (trst_nxt && ctrl0_r.converter_power_on && st_r == ST_ACQ &&
        !start && !abort) begin
      start        = 1'b1;
      ctrl0_nxt.go = 1'b1;
    end
    case (st_r)
      ST_ACQ: begin
        if (start) begin
          st_nxt      = ST_CONV;
          tad_cnt_nxt = 4'd0;
        end
      end
      ST_CONV: begin
        if (abort) begin
          st_nxt       = ST_ABORT;
          ctrl0_nxt.go = 1'b0;
          tad_cnt_nxt  = 4'd0;
        end else if (tad_tick && tad_cnt_r == CONV_TADS - 4'd1) begin
          done         = 1'b1;
          st_nxt       = ST_ACQ;
          ctrl0_nxt.go = 1'b0;
          if (ctrl1_r.result_format_select) begin
            res_hi_nxt = {6'd0, sar_result_in[9:8]};
            res_lo_nxt = sar_result_in[7:0];
          end else begin
            res_hi_nxt = sar_result_in[9:2];
            res_lo_nxt = {sar_result_in[1:0], 6'd0};
          end
        end else if (tad_tick) begin
          tad_cnt_nxt = tad_cnt_r + 4'd1;
        end
      end
      ST_ABORT: begin
        if (tad_tick && tad_cnt_r == ABORT_TADS - 4'd1) begin
          st_nxt = ST_ACQ;
        end else if (tad_tick) begin
          tad_cnt_nxt = tad_cnt_r + 4'd1;
        end
      end
      default: st_nxt = ST_ACQ;
    endcase
    // the done flag is set last so that it beats a clearing write
    if (done) irqf_nxt[DONE_BIT] = 1'b1;
    samp_nxt = (st_nxt == ST_ACQ);
    step_nxt = (st_r == ST_CONV) && tad_tick;
  end

  // ************************************************************
  // flip-flops; power-on reset clears control, results untouched
  // ************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r      <= ST_ACQ;
      ctrl0_r   <= adcs_ctrl0_t'(CTRL0_RST);
      ctrl1_r   <= adcs_ctrl1_t'(CTRL1_RST);
      irqf_r    <= IRQF_RST;
      irqe_r    <= IRQE_RST;
      irqp_r    <= IRQP_RST;
      tad_cnt_r <= 4'd0;
      samp_r    <= 1'b1;
      step_r    <= 1'b0;
      trst_r    <= 1'b0;
    end else if (soft_rst) begin
      st_r      <= ST_ACQ;
      ctrl0_r   <= adcs_ctrl0_t'(CTRL0_RST);
      ctrl1_r   <= adcs_ctrl1_t'(CTRL1_RST);
      irqf_r    <= IRQF_RST;
      irqe_r    <= IRQE_RST;
      irqp_r    <= IRQP_RST;
      tad_cnt_r <= 4'd0;
      samp_r    <= 1'b1;
      step_r    <= 1'b0;
      trst_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      ctrl0_r   <= ctrl0_nxt;
      ctrl1_r   <= ctrl1_nxt;
      irqf_r    <= irqf_nxt;
      irqe_r    <= irqe_nxt;
      irqp_r    <= irqp_nxt;
      tad_cnt_r <= tad_cnt_nxt;
      samp_r    <= samp_nxt;
      step_r    <= step_nxt;
      trst_r    <= trst_nxt;
    end
  end

  // result pair carries no reset: contents are unknown after power-on
  always_ff @(posedge clk_sys) begin
    res_hi_r <= res_hi_nxt;
    res_lo_r <= res_lo_nxt;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
      arready_r <= 1'b1;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready        = ~aw_have_r;
  assign s_axi_wready         = ~w_have_r;
  assign s_axi_bvalid         = bvalid_r;
  assign s_axi_bresp          = bresp_r;
  assign s_axi_arready        = arready_r;
  assign s_axi_rvalid         = rvalid_r;
  assign s_axi_rdata          = rdata_r;
  assign s_axi_rresp          = rresp_r;
  assign sample_en            = samp_r;
  assign sar_step             = step_r;
  assign timer_reset          = trst_r;
  assign input_channel_select = ctrl0_r.input_channel_select;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n || soft_rst);

  AST_TWELVE_TADS: assert property (done |-> tad_tick && tad_cnt_r == 4'd11)
    else $error("conversion ended before twelve bit periods");
  AST_SWITCH_OPEN: assert property (start |=> !sample_en [*2])
    else $error("sampling switch not open after start");
  AST_ABORT_NOW: assert property (st_r == ST_CONV && abort |=> st_r == ST_ABORT)
    else $error("abort not taken at once");
  AST_ABORT_KEEPS: assert property (st_r == ST_ABORT && !wr_fire |=> $stable(res_hi_r) && $stable(res_lo_r))
    else $error("result changed during abort");
  AST_ABORT_WAIT: assert property ($rose(st_r == ST_ABORT) |-> !sample_en)
    else $error("acquisition resumed without the abort wait");
  AST_RIGHT_JUST: assert property (done && ctrl1_r.result_format_select |=> res_hi_r[7:2] == 6'd0)
    else $error("right justified high bits not zero");
  AST_LEFT_JUST: assert property (done && !ctrl1_r.result_format_select |=> res_lo_r[5:0] == 6'd0)
    else $error("left justified low bits not zero");
  AST_TRIG_START: assert property (special_trigger && compare_unit_mode == TRIG_MODE
      && ctrl0_r.converter_power_on && st_r == ST_ACQ |=> st_r == ST_CONV && timer_reset)
    else $error("trigger did not start conversion");
  AST_TRIG_OFF: assert property (special_trigger && compare_unit_mode == TRIG_MODE
      && !ctrl0_r.converter_power_on && st_r == ST_ACQ |=> st_r == ST_ACQ && timer_reset)
    else $error("unpowered trigger mishandled");
  AST_DONE_FLAGS: assert property (done |=> !ctrl0_r.go && irqf_r[DONE_BIT] && sample_en)
    else $error("completion flags wrong");

endmodule // adcs_sequencer

`default_nettype wire

/* File: testbench/adcs_sah_model.sv */
/*
 * adcs_sah_model: stand-in for the sample-and-hold and bit array.
 * Assumes the bench drives an analog level and the sequencer drives sample_en.
 */
`timescale 1ns/1ps
`default_nettype none

module adcs_sah_model (
  // analog side
  input  wire logic [9:0] level_in,
  // converter side
  input  wire logic       sample_en,
  output logic [9:0]      sar_result_in,
  output var logic        rc_tick_in
);
  // ************************************************************
  // hold capacitor and result
  // ************************************************************
  logic [9:0] held_r;

  // tracks only while the switch is closed
  always @* if (sample_en) held_r = level_in;
  // outside a conversion the result lines carry junk, so early sampling shows
  assign sar_result_in = sample_en ? ~held_r : held_r;

  // free running rc source, phase unrelated to the system clock
  initial rc_tick_in = 1'b0;
  always #37 rc_tick_in = ~rc_tick_in;
endmodule // adcs_sah_model

`default_nettype wire

/* File: testbench/adcs_sequencer_tb.sv */
/*
 * adcs_sequencer_tb: self-checking bench for the conversion sequencer.
 * Assumes a 100 MHz clock; bready and rready are held high throughout.
 */
`timescale 1ns/1ps
`default_nettype none

module adcs_sequencer_tb;
  import adcs_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk_sys = 0, arst_n = 0, soft_rst = 0, trig = 0;
  logic aw_v = 0, w_v = 0, ar_v = 0, aw_rdy, w_rdy, ar_rdy, b_v, r_v;
  logic [7:0] aw_a = 0, ar_a = 0, pins = 0;
  logic [31:0] w_d = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] cmode = 0;
  logic [9:0] level = 0, sar_res;
  logic rc_tk, samp, step, tmr_rst;
  logic [2:0] chan;
  logic [15:0] eres;
  int seed = 53, bad_count = 0, num_checks = 0, low_cnt = 0, low_len = 0, step_n = 0;
  logic [3:0] cfgs[3] = '{4'b0000, 4'b0110, 4'b1110};
  logic [7:0] masks[3] = '{8'hFF, 8'h00, 8'h01};

  always #5 clk_sys = ~clk_sys;

  adcs_sequencer uut (.clk_sys(clk_sys), .arst_n(arst_n), .soft_rst(soft_rst),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'h1), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(1'b1),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(1'b1),
    .sar_result_in(sar_res), .rc_tick_in(rc_tk), .sample_en(samp), .sar_step(step),
    .input_channel_select(chan), .special_trigger(trig), .compare_unit_mode(cmode),
    .timer_reset(tmr_rst), .port_pins_in(pins));

  adcs_sah_model sah (.level_in(level), .sample_en(samp), .sar_result_in(sar_res),
    .rc_tick_in(rc_tk));

  // length of the last low stretch of sample_en, in cycles
  always @(posedge clk_sys) if (!samp) low_cnt <= low_cnt + 1;
    else if (low_cnt != 0) begin
      low_len <= low_cnt;
      low_cnt <= 0;
    end
  // running count of bit-period step pulses
  always @(posedge clk_sys) if (step === 1'b1) step_n <= step_n + 1;

  // ************************************************************
  // expectations and bus tasks
  // ************************************************************
  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a[1:0] == 2'b00 && a <= ADDR_PORT) ? RESP_OKAY : RESP_SLVERR;
  endfunction
  function automatic int tadp(input logic [2:0] c);
    case (c)
      3'b000: return 2;
      3'b100: return 4;
      3'b001: return 8;
      3'b101: return 16;
      3'b010: return 32;
      3'b110: return 64;
      default: return 0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: both channels offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_sys);
      ta = ta | (aw_rdy === 1'b1);
      tw = tw | (w_rdy === 1'b1);
      @(posedge clk_sys);
      aw_v <= !ta;
      w_v <= !tw;
    end
    do @(negedge clk_sys); while (b_v !== 1'b1);
    chk(bresp, exp_resp(a));
    @(posedge clk_sys);
  endtask
  task automatic axr(input logic [7:0] a, input logic [7:0] e);
    logic g;
    g = 0;
    ar_a <= a;
    ar_v <= 1'b1;
    while (!g) begin
      @(negedge clk_sys);
      g = (ar_rdy === 1'b1);
      @(posedge clk_sys);
      ar_v <= !g;
    end
    do @(negedge clk_sys); while (r_v !== 1'b1);
    chk(rresp, exp_resp(a));
    chk(rdata, {24'h0, e});
    @(posedge clk_sys);
  endtask
  // two edges after the rise so the stretch and step counters have settled
  task automatic wait_done;
    do @(negedge clk_sys); while (samp !== 1'b1);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic regs_rst;
    axr(ADDR_CTRL0, CTRL0_RST);
    axr(ADDR_CTRL1, CTRL1_RST);
    axr(ADDR_IRQF, IRQF_RST);
    axr(ADDR_IRQP, IRQP_RST);
  endtask
  // one conversion on code c; the level moves once the switch has opened
  task automatic conv(input logic [2:0] c, input logic f);
    logic [9:0] v;
    int s0;
    v = 10'($random(seed));
    level <= v;
    axw(ADDR_CTRL1, {f, c[2], 6'h00});
    axw(ADDR_CTRL0, {c[1:0], c, 3'b001});
    axw(ADDR_IRQF, 8'h00);
    repeat (20) @(posedge clk_sys);
    s0 = step_n;
    axw(ADDR_CTRL0, {c[1:0], c, 3'b101});
    level <= ~v;
    wait_done();
    chk(step_n - s0, 12);
    eres = f ? {6'h0, v} : {v, 6'h0};
    if (c[1:0] != 2'b11) chk(low_len, 12 * tadp(c));
    else chk(low_len inside {[80:140]}, 1);
    axr(ADDR_RES_HI, eres[15:8]);
    axr(ADDR_RES_LO, eres[7:0]);
    axr(ADDR_CTRL0, {c[1:0], c, 3'b001});
    axr(ADDR_IRQF, 8'h40);
    chk(chan, c);
  endtask
  task automatic trg(input logic [3:0] m, input logic ex);
    logic t;
    cmode <= m;
    @(posedge clk_sys);
    trig <= 1'b1;
    @(posedge clk_sys);
    trig <= 1'b0;
    @(negedge clk_sys);
    t = tmr_rst;
    @(negedge clk_sys);
    chk(t | tmr_rst, m == TRIG_MODE);
    chk(samp, !ex);
    @(posedge clk_sys);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    logic [7:0] pv;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    regs_rst();
    axr(8'h20, 8'h00);
    axw(8'h22, 8'h5A);
    axw(ADDR_IRQE, 8'h40);
    axr(ADDR_IRQE, 8'h40);
    axw(ADDR_CTRL0, 8'h05);
    axr(ADDR_CTRL0, 8'h01);
    chk(samp, 1);
    $display("test registers done");
    axw(ADDR_CTRL0, 8'h00);
    eres = 16'($random(seed));
    axw(ADDR_RES_HI, eres[15:8]);
    axw(ADDR_RES_LO, eres[7:0]);
    axr(ADDR_RES_HI, eres[15:8]);
    axr(ADDR_RES_LO, eres[7:0]);
    axw(ADDR_CTRL1, 8'h8F);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    @(posedge clk_sys);
    regs_rst();
    axr(ADDR_RES_HI, eres[15:8]);
    $display("test storage and soft reset done");
    for (int i = 0; i < 8; i++) conv(3'(i), i[0]);
    $display("test conversions done");
    // abort on the slowest divider, partway through
    axw(ADDR_CTRL1, 8'h40);
    axw(ADDR_CTRL0, 8'h81);
    axw(ADDR_CTRL0, 8'h85);
    repeat (100) @(posedge clk_sys);
    axw(ADDR_CTRL0, 8'h81);
    wait_done();
    chk(low_len inside {[166:240]}, 1);
    axr(ADDR_RES_HI, eres[15:8]);
    axr(ADDR_RES_LO, eres[7:0]);
    $display("test abort done");
    axw(ADDR_CTRL0, 8'h01);
    axw(ADDR_IRQF, 8'h00);
    repeat (20) @(posedge clk_sys);
    trg(TRIG_MODE, 1'b1);
    wait_done();
    axr(ADDR_IRQF, 8'h40);
    axr(ADDR_CTRL0, 8'h01);
    trg(4'b0000, 1'b0);
    axw(ADDR_CTRL0, 8'h00);
    trg(TRIG_MODE, 1'b0);
    $display("test trigger done");
    for (int j = 0; j < 3; j++) begin
      pv = 8'($random(seed));
      pins <= pv;
      axw(ADDR_CTRL1, {4'h0, cfgs[j]});
      axr(ADDR_PORT, pv & ~masks[j]);
    end
    $display("test port view done");
    give_verdict();
  end

  // watchdog, well beyond the expected run of a few thousand cycles
  initial begin
    #300000;
    bad_count++;
    give_verdict();
  end
endmodule // adcs_sequencer_tb

`default_nettype wire
